/* File: core/adc_record_control_regs.v */
`timescale 1ns/1ps
`include "adc_record_consts.vh"

module adc_record_control_regs #(
  parameter DATA_W = 24
) (
  input  wire                     ref_clk,
  input  wire                     rst_n,
  input  wire [6:0]               reg_addr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_write,
  input  wire                     reg_read,
  output reg  [7:0]               reg_rdata,
  input  wire                     in_valid,
  input  wire signed [DATA_W-1:0] in_left,
  input  wire signed [DATA_W-1:0] in_right,
  output reg                      out_valid,
  output wire [DATA_W-1:0]        out_left,
  output wire [DATA_W-1:0]        out_right,
  output wire [5:0]               left_gain_applied,
  output wire [5:0]               right_gain_applied,
  output wire                     left_amp_power_down,
  output wire                     right_amp_power_down,
  output wire                     analog_section_power_down,
  output wire                     converter_power_down,
  output wire                     reference_buffer_power_down,
  output wire                     master_clock_tick,
  output wire                     modulator_clock_tick
);

  localparam MAG_W = DATA_W - 1;

  reg  [5:0]            left_input_gain_code;
  reg  [5:0]            right_input_gain_code;
  reg  [7:0]            control_one;
  reg  [7:0]            control_two;
  reg  [7:0]            record_volume_left;
  reg  [7:0]            record_volume_right;
  reg  [1:0]            master_count;
  reg  [2:0]            mod_count;
  wire [1:0]            master_clock_divide_select;
  wire                  modulator_clock_select;
  wire                  run;
  wire [1:0]            peak_clear;
  wire [6:0]            record_volume [0:1];
  wire                  record_mute [0:1];
  wire signed [DATA_W-1:0] chan_in [0:1];
  wire [DATA_W-1:0]     chan_out [0:1];
  wire [5:0]            record_peak [0:1];
  wire [1:0]            next_master_last;
  wire [2:0]            mod_div;

  ////////////////////////////////////////////////////////////////////////////
  // peak magnitude to level code, one dB per step below full scale
  // each octave of the leading one is six steps; the next three bits refine it
  // a zero magnitude reads as the floor code, the quietest level the field holds
  function [5:0] peak_code;
    input [MAG_W-1:0] m;
    integer i;
    integer p;
    integer d;
    reg [MAG_W+2:0] s;
    reg [2:0] f;
    begin
      p = -1;
      d = 0;
      s = {MAG_W+3{1'b0}};
      f = 3'h0;
      for (i = 0; i < MAG_W; i = i + 1) begin
        if (m[i]) begin
          p = i;
        end
      end
      if (p < 0) begin
        peak_code = `PEAK_FLOOR;
      end else begin
        s = {m, 3'h0} >> p;
        f = s[2:0];
        d = `PEAK_DB_PER_BIT * (MAG_W - 1 - p);
        case (f)
          3'h7, 3'h6: d = d + 1;
          3'h5:       d = d + 2;
          3'h4, 3'h3: d = d + 3;
          3'h2:       d = d + 4;
          3'h1:       d = d + 5;
          default:    d = d + 6;
        endcase
        if (d > `PEAK_FLOOR) begin
          peak_code = `PEAK_FLOOR;
        end else begin
          peak_code = d[5:0];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control fields steering the analog side
  // the dividers and the sample path stop for as long as the converter is down
  assign modulator_clock_select      = control_one[`C1_MOD_CLK];
  assign master_clock_divide_select  = control_two[1:0];
  assign converter_power_down        = control_one[`C1_CONV_PD];
  assign run                         = ~converter_power_down;
  // whole converter down takes the analog section and both amplifiers with it
  assign analog_section_power_down   = control_one[`C1_ANALOG_SECTION_POWER_DOWN] | converter_power_down;
  assign left_amp_power_down         = control_one[`C1_AMP_PD_L] | converter_power_down;
  assign right_amp_power_down        = control_one[`C1_AMP_PD_R] | converter_power_down;
  assign reference_buffer_power_down = control_two[`C2_REFERENCE_BUFFER_POWER_DOWN];

  // gain codes past 24 dB clamp
  assign left_gain_applied  = (left_input_gain_code > `GAIN_MAX) ?
                              `GAIN_MAX : left_input_gain_code;
  assign right_gain_applied = (right_input_gain_code > `GAIN_MAX) ?
                              `GAIN_MAX : right_input_gain_code;

  ////////////////////////////////////////////////////////////////////////////
  // register writes, reserved bits dropped
  // peak level addresses are not decoded, so host writes to them fall away
  // only six gain bits are stored, so the reserved top bits cannot be set
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_input_gain_code  <= `RST_GAIN;
      right_input_gain_code <= `RST_GAIN;
      control_one           <= `RST_CONTROL_ONE;
      control_two           <= `RST_CONTROL_TWO;
      record_volume_left    <= `RST_VOLUME;
      record_volume_right   <= `RST_VOLUME;
    end else if (reg_write) begin
      if (reg_addr == `ADDR_LEFT_GAIN) begin
        left_input_gain_code <= reg_wdata[5:0];
      end else if (reg_addr == `ADDR_RIGHT_GAIN) begin
        right_input_gain_code <= reg_wdata[5:0];
      end else if (reg_addr == `ADDR_CONTROL_ONE) begin
        control_one <= reg_wdata;
      end else if (reg_addr == `ADDR_CONTROL_TWO) begin
        control_two <= reg_wdata & `C2_MASK;
      end else if (reg_addr == `ADDR_LEFT_VOLUME) begin
        record_volume_left <= reg_wdata;
      end else if (reg_addr == `ADDR_RIGHT_VOLUME) begin
        record_volume_right <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, peak levels are read-only and unmapped reads give zero
  // bit 7 of each volume register is kept for read-back but does not scale
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == `ADDR_LEFT_GAIN) begin
        reg_rdata <= {2'h0, left_input_gain_code};
      end else if (reg_addr == `ADDR_RIGHT_GAIN) begin
        reg_rdata <= {2'h0, right_input_gain_code};
      end else if (reg_addr == `ADDR_CONTROL_ONE) begin
        reg_rdata <= control_one;
      end else if (reg_addr == `ADDR_CONTROL_TWO) begin
        reg_rdata <= control_two;
      end else if (reg_addr == `ADDR_LEFT_VOLUME) begin
        reg_rdata <= record_volume_left;
      end else if (reg_addr == `ADDR_RIGHT_VOLUME) begin
        reg_rdata <= record_volume_right;
      end else if (reg_addr == `ADDR_LEFT_PEAK) begin
        reg_rdata <= {2'h0, record_peak[0]};
      end else if (reg_addr == `ADDR_RIGHT_PEAK) begin
        reg_rdata <= {2'h0, record_peak[1]};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // a read of a peak level restarts its detector
  // the host sees the level held up to its read, then a fresh hold begins
  assign peak_clear[0] = reg_read && (reg_addr == `ADDR_LEFT_PEAK);
  assign peak_clear[1] = reg_read && (reg_addr == `ADDR_RIGHT_PEAK);

  ////////////////////////////////////////////////////////////////////////////
  // master clock divider, then modulator divider
  // code 11 is not decoded and falls back to divide by one
  // counters compare with >= so a divide change never strands them past the end
  assign next_master_last = (master_clock_divide_select == `DIV_BY_TWO)   ? 2'h1 :
                            (master_clock_divide_select == `DIV_BY_THREE) ? 2'h2 :
                            2'h0;
  assign master_clock_tick = run && (master_count >= next_master_last);
  assign mod_div = modulator_clock_select ? `MOD_DIV_SLOW : `MOD_DIV_FAST;
  assign modulator_clock_tick = master_clock_tick && (mod_count >= mod_div - 3'h1);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_count <= 2'h0;
      mod_count    <= 3'h0;
    end else if (!run) begin
      master_count <= 2'h0;
      mod_count    <= 3'h0;
    end else if (master_clock_tick) begin
      master_count <= 2'h0;
      mod_count    <= modulator_clock_tick ? 3'h0 : mod_count + 3'h1;
    end else begin
      master_count <= master_count + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel record path: filter, volume, mute, peak detector
  // levels are measured after mute and volume, as the recorded stream sees them
  assign chan_in[0]       = in_left;
  assign chan_in[1]       = in_right;
  assign record_volume[0] = record_volume_left[6:0];
  assign record_volume[1] = record_volume_right[6:0];
  assign record_mute[0]   = control_one[`C1_MUTE_L];
  assign record_mute[1]   = control_one[`C1_MUTE_R];
  assign out_left         = chan_out[0];
  assign out_right        = chan_out[1];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg  signed [DATA_W+1:0] x_prev;
      reg  signed [DATA_W+1:0] y_prev;
      reg  signed [DATA_W-1:0] sample_out;
      reg         [MAG_W-1:0]  peak_mag;
      wire signed [DATA_W+1:0] x_ext;
      wire signed [DATA_W+1:0] y_raw;
      wire signed [DATA_W-1:0] filtered;
      wire        [8:0]        mult;
      wire signed [DATA_W+9:0] product;
      wire signed [DATA_W-1:0] scaled;
      wire        [DATA_W-1:0] mag_full;
      wire        [MAG_W-1:0]  mag;

      // first-order dc blocker
      assign x_ext = {{2{chan_in[ch][DATA_W-1]}}, chan_in[ch]};
      assign y_raw = x_ext - x_prev + y_prev - (y_prev >>> `HPF_SHIFT);
      assign filtered = !control_one[`C1_HPF] ? chan_in[ch] :
        (y_raw > $signed({3'h0, {MAG_W{1'b1}}})) ? {1'b0, {MAG_W{1'b1}}} :
        (y_raw < -$signed({3'h0, {MAG_W{1'b1}}})) ? {1'b1, {MAG_W-1{1'b0}}, 1'b1} :
        y_raw[DATA_W-1:0];

      // linear volume in 1/128 steps from 1/256 at code zero, all ones is exact unity
      assign mult = (record_volume[ch] == `VOL_UNITY_CODE) ? `VOL_UNITY_MULT :
                    {1'b0, record_volume[ch], 1'b1};
      assign product = filtered * $signed({1'b0, mult});
      assign scaled = record_mute[ch] ? {DATA_W{1'b0}} :
                      product[DATA_W+`VOL_SHIFT-1:`VOL_SHIFT];

      // magnitude, most negative value clamped to full scale
      assign mag_full = scaled[DATA_W-1] ? (~scaled + 1'b1) : scaled;
      assign mag = mag_full[DATA_W-1] ? {MAG_W{1'b1}} : mag_full[MAG_W-1:0];

      // filter state runs only with filter on and converter up
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          x_prev <= {DATA_W+2{1'b0}};
          y_prev <= {DATA_W+2{1'b0}};
        end else if (!control_one[`C1_HPF] || !run) begin
          x_prev <= {DATA_W+2{1'b0}};
          y_prev <= {DATA_W+2{1'b0}};
        end else if (in_valid) begin
          x_prev <= x_ext;
          y_prev <= {{2{filtered[DATA_W-1]}}, filtered};
        end
      end

      // output sample register
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sample_out <= {DATA_W{1'b0}};
        end else if (in_valid && run) begin
          sample_out <= scaled;
        end
      end

      // peak hold; a new sample wins over a clearing read
      // so a sample landing on the read's edge is never lost between two reads
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          peak_mag <= {MAG_W{1'b0}};
        end else if (in_valid && run && (peak_clear[ch] || mag > peak_mag)) begin
          peak_mag <= mag;
        end else if (peak_clear[ch]) begin
          peak_mag <= {MAG_W{1'b0}};
        end
      end

      assign chan_out[ch]    = sample_out;
      assign record_peak[ch] = peak_code(peak_mag);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // output strobe, silent while powered down
  // samples offered during power-down vanish without an answer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid && run;
    end
  end

endmodule

/* File: shared/adc_record_consts.vh */
// Operation
// - left amplifier gain: six bits, 0.5 dB per step, 0 dB up to 24 dB
// - right amplifier gain in bits 5:0; codes above 110000 clamp to 24 dB
// - modulator clock: master clock divided by 2 when clear, by 4 when set
// - control one bit 6 enables the record path high-pass filter
// - bit 5 powers down the whole converter, bit 4 only its analog section
// - control one bits 1 and 0 power down left and right amplifiers
// - control one bit 3 mutes the right record output
// - control one bit 2 mutes the left record output
// - control two bit 4 powers down the reference buffer
// - master clock divider: 00 by one, 01 by two, 10 by three, 11 by one
// - left volume scales linearly: all ones unity, 1000000 half, zero 1/256
// - right volume uses the same linear scaling as the left
// - left peak level: six bits, one dB per step, 000000 full scale
// - right peak level: same coding, 111111 means -63 dBFS
// - left amplifier gain sits in bits 5:0 at 0x6c, upper bits reserved
`ifndef ADC_RECORD_CONSTS_VH
`define ADC_RECORD_CONSTS_VH

// register addresses on the control port
`define ADDR_LEFT_GAIN     7'h6c
`define ADDR_RIGHT_GAIN    7'h6d
`define ADDR_CONTROL_ONE   7'h6e
`define ADDR_CONTROL_TWO   7'h6f
`define ADDR_LEFT_VOLUME   7'h70
`define ADDR_RIGHT_VOLUME  7'h71
`define ADDR_LEFT_PEAK     7'h72
`define ADDR_RIGHT_PEAK    7'h73

// control one fields
`define C1_MOD_CLK         7
`define C1_HPF             6
`define C1_CONV_PD         5
`define C1_ANALOG_SECTION_POWER_DOWN          4
`define C1_MUTE_R          3
`define C1_MUTE_L          2
`define C1_AMP_PD_L        1
`define C1_AMP_PD_R        0

// control two fields
`define C2_REFERENCE_BUFFER_POWER_DOWN          4
`define C2_MASK            8'h13

// reset values
`define RST_GAIN           6'h00
`define RST_CONTROL_ONE    8'h00
`define RST_CONTROL_TWO    8'h00
`define RST_VOLUME         8'h7f

// codes and limits
`define GAIN_MAX           6'h30
`define DIV_BY_TWO         2'h1
`define DIV_BY_THREE       2'h2
`define MOD_DIV_SLOW       3'h4
`define MOD_DIV_FAST       3'h2
`define VOL_UNITY_CODE     7'h7f
`define VOL_UNITY_MULT     9'h100
`define VOL_SHIFT          8
`define PEAK_FLOOR         6'h3f
`define PEAK_DB_PER_BIT    6
`define HPF_SHIFT          10

`endif

/* File: testbench/adc_record_checker.sv */
`timescale 1ns/1ps
module adc_record_checker (
  input logic       ref_clk,
  input logic       rst_n,
  input logic [6:0] reg_addr,
  input logic       reg_read,
  input logic [7:0] reg_rdata,
  input logic       in_valid,
  input logic       out_valid,
  input logic [5:0] left_gain_applied,
  input logic [5:0] right_gain_applied,
  input logic       left_amp_power_down,
  input logic       right_amp_power_down,
  input logic       analog_section_power_down,
  input logic       converter_power_down,
  input logic       master_clock_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  a_left_gain_clamp: assert property (left_gain_applied <= 6'h30)
    else $error("left gain above clamp");
  a_right_gain_clamp: assert property (right_gain_applied <= 6'h30)
    else $error("right gain above clamp");
  a_pd_covers_analog: assert property (converter_power_down |-> analog_section_power_down)
    else $error("analog section up while converter down");
  a_pd_covers_amps: assert property (converter_power_down |->
    left_amp_power_down && right_amp_power_down)
    else $error("amplifier up while converter down");
  a_sample_answer: assert property (in_valid && !converter_power_down |=> out_valid)
    else $error("accepted sample gave no out_valid");
  a_pd_refuses: assert property (in_valid && converter_power_down |=> !out_valid)
    else $error("sample taken while converter down");
  a_pd_stops_clock: assert property (converter_power_down [*2] |-> !master_clock_tick)
    else $error("master tick while converter down");
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_read && reg_addr > 7'h73 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind adc_record_control_regs adc_record_checker chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .in_valid(in_valid), .out_valid(out_valid),
  .left_gain_applied(left_gain_applied), .right_gain_applied(right_gain_applied),
  .left_amp_power_down(left_amp_power_down), .right_amp_power_down(right_amp_power_down),
  .analog_section_power_down(analog_section_power_down),
  .converter_power_down(converter_power_down), .master_clock_tick(master_clock_tick));

/* File: testbench/adc_host.sv */
`timescale 1ns/1ps
module adc_host (
  input  logic       ref_clk,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_write,
  output logic       reg_read,
  input  logic [7:0] reg_rdata
);
  // idle control port at time zero
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one write strobe; lines scrambled once released
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  // one read strobe; data taken after the taking edge settles
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

/* File: testbench/adc_record_control_regs_bench.sv */
`timescale 1ns/1ps
module adc_record_control_regs_bench;
  logic               ref_clk, rst_n, in_valid;
  logic signed [23:0] in_left, in_right;
  wire  [6:0]         reg_addr;
  wire  [7:0]         reg_wdata, reg_rdata;
  wire                reg_write, reg_read, out_valid, master_clock_tick, modulator_clock_tick;
  wire  [23:0]        out_left, out_right;
  wire  [5:0]         left_gain_applied, right_gain_applied;
  wire                left_amp_power_down, right_amp_power_down, analog_section_power_down;
  wire                converter_power_down, reference_buffer_power_down;
  int                 num_errors, num_checks, cycles, m, k;
  logic [7:0]         rv;
  int                 divs[4] = '{1, 2, 3, 1};

  adc_record_control_regs adc_record_control_regs_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .in_valid, .in_left, .in_right, .out_valid, .out_left,
    .out_right, .left_gain_applied, .right_gain_applied, .left_amp_power_down,
    .right_amp_power_down, .analog_section_power_down, .converter_power_down,
    .reference_buffer_power_down, .master_clock_tick, .modulator_clock_tick);
  adc_host adc_host_i (.ref_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);

  ////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task rdchk(input logic [6:0] a, input logic [7:0] exp);
    adc_host_i.rd(a, rv);
    chk("read data", {16'h0000, rv}, {16'h0000, exp});
  endtask
  // one stereo sample, answer judged in its single valid cycle
  task samp(input int l, input int r, input int el, input int er);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    #1 chk("out valid", out_valid, 24'h1);
    chk("out left", out_left, el);
    chk("out right", out_right, er);
  endtask
  task ticks(input int n);
    m = 0;
    k = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      m += master_clock_tick;
      k += modulator_clock_tick;
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task t_reset_and_gain;
    rdchk(7'h6c, 8'h00);
    rdchk(7'h6e, 8'h00);
    rdchk(7'h70, 8'h7f);
    rdchk(7'h71, 8'h7f);
    rdchk(7'h74, 8'h00);
    adc_host_i.wr(7'h6c, 8'hff);
    rdchk(7'h6c, 8'h3f);
    chk("left gain", left_gain_applied, 24'h30);
    adc_host_i.wr(7'h6c, 8'h2f);
    chk("left gain", left_gain_applied, 24'h2f);
    adc_host_i.wr(7'h6d, 8'h31);
    chk("right gain", right_gain_applied, 24'h30);
    rdchk(7'h6d, 8'h31);
  endtask
  task t_control_one;
    for (int b = 0; b < 8; b++) begin
      adc_host_i.wr(7'h6e, 8'h01 << b);
      rdchk(7'h6e, 8'h01 << b);
      chk("left amp pd", left_amp_power_down, b == 1 || b == 5);
      chk("right amp pd", right_amp_power_down, b == 0 || b == 5);
      chk("analog pd", analog_section_power_down, b == 4 || b == 5);
      chk("converter pd", converter_power_down, b == 5);
    end
    adc_host_i.wr(7'h6e, 8'h20);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    #1 chk("refused valid", out_valid, 24'h0);
  endtask
  task t_clocks;
    adc_host_i.wr(7'h6e, 8'h00);
    adc_host_i.wr(7'h6f, 8'hff);
    rdchk(7'h6f, 8'h13);
    chk("buffer pd", reference_buffer_power_down, 24'h1);
    for (int c = 0; c < 4; c++) begin
      adc_host_i.wr(7'h6f, c);
      chk("buffer pd", reference_buffer_power_down, 24'h0);
      ticks(6);
      ticks(12);
      chk("master ticks", m, 12 / divs[c]);
    end
    for (int s = 0; s < 2; s++) begin
      adc_host_i.wr(7'h6e, {s[0], 7'h00});
      ticks(8);
      ticks(24);
      chk("modulator ticks", k, s ? 6 : 12);
    end
  endtask
  task t_samples;
    adc_host_i.wr(7'h6e, 8'h00);
    samp(1000, -1000, 1000, -1000);
    adc_host_i.wr(7'h70, 8'h40);
    adc_host_i.wr(7'h71, 8'h3f);
    samp(1000, 1000, 503, 496);
    adc_host_i.wr(7'h70, 8'h00);
    adc_host_i.wr(7'h71, 8'h7e);
    samp(1000, 1000, 3, 988);
    adc_host_i.wr(7'h70, 8'h7f);
    adc_host_i.wr(7'h71, 8'h7f);
    adc_host_i.wr(7'h6e, 8'h08);
    adc_host_i.rd(7'h73, rv);
    samp(500, 500, 500, 0);
    rdchk(7'h73, 8'h3f);
    adc_host_i.wr(7'h6e, 8'h04);
    adc_host_i.rd(7'h72, rv);
    samp(500, 500, 0, 500);
    adc_host_i.wr(7'h72, 8'h00);
    rdchk(7'h72, 8'h3f);
    adc_host_i.wr(7'h6e, 8'h00);
    samp(4194304, -4194304, 4194304, -4194304);
    rdchk(7'h72, 8'h06);
    rdchk(7'h73, 8'h06);
    adc_host_i.wr(7'h6e, 8'h40);
    samp(4096, 4096, 4096, 4096);
    samp(4096, 4096, 4092, 4092);
  endtask

  ////////////////////////////////////////////////////////////////
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict;
    end
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_left = 24'h000000;
    in_right = 24'h000000;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_and_gain;
    t_control_one;
    t_clocks;
    t_samples;
    print_verdict;
  end
endmodule
